//--- src/bmf_cfg.svh
// Constants for the bus-matching FIFO port control block
// Assumes inclusion by the package, the design module and the bench
`ifndef BMF_CFG_SVH
`define BMF_CFG_SVH
// ***********************************
// Sizes
// ***********************************
`define BMF_DEPTH 11'h0400
`define BMF_PTR_W 10
`define BMF_CNT_W 11
`define BMF_DW 36
// ***********************************
// Default offsets
// ***********************************
`define BMF_OFS_64 10'h040
`define BMF_OFS_16 10'h010
`define BMF_OFS_8 10'h008
// ***********************************
// Register map and fields
// ***********************************
`define BMF_OFFS_ADDR 32'h0000_0000
`define BMF_STAT_ADDR 32'h0000_0004
`define BMF_X_LSB 0
`define BMF_Y_LSB 16
`define BMF_RESP_OKAY 2'h0
`define BMF_RESP_SLVERR 2'h2
`endif

//--- src/bmf_pkg.sv
// Types for the bus-matching FIFO port control block
// Assumes bmf_cfg.svh on the include path
`include "bmf_cfg.svh"
package bmf_pkg;
   // Pin bundle, passed through the input synchroniser
   typedef struct packed {
      logic pa_clk;
      logic pa_sel_n;
      logic pa_dir;
      logic pa_stb;
      logic pa_mb;
      logic [`BMF_DW-1:0] pa_d;
      logic pb_clk;
      logic pb_sel_n;
      logic pb_dir;
      logic pb_stb;
      logic pb_mb;
      logic [`BMF_DW-1:0] pb_d;
      logic mrs_n;
      logic serial_program_mode;
      logic fs1;
      logic fs0;
      logic be;
      logic fall_through_mode;
      logic bm;
      logic size;
   } bmf_pins_t;

   typedef struct packed {
      bmf_pins_t s1;
      bmf_pins_t s2;
      logic a3;
      logic b3;
      logic m3;
      logic live;
      logic be;
      logic [`BMF_PTR_W-1:0] x;
      logic [`BMF_PTR_W-1:0] y;
      logic [1:0] prog;
      logic [`BMF_PTR_W-1:0] wp;
      logic [`BMF_PTR_W-1:0] rp;
      logic [`BMF_CNT_W-1:0] cnt;
      logic [`BMF_DW-1:0] word;
      logic [1:0] lane;
      logic valid;
      logic [`BMF_DW-1:0] mb1;
      logic [`BMF_DW-1:0] mb2;
      logic mf1;
      logic mf2;
      logic [`BMF_DW-1:0] pa_do;
      logic [`BMF_DW-1:0] pb_do;
      logic pa_oe;
      logic pb_oe;
      logic ef;
      logic ae;
      logic af;
      logic ff;
      logic awr;
      logic bv;
      logic [1:0] bresp;
      logic arr;
      logic rv;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } bmf_st_t;
endpackage : bmf_pkg

//--- src/bmf_port_ctrl.sv
// Port control, flags, mailboxes and port B bus matching of a 36-bit FIFO
// Assumes all pins asynchronous to ref_clk_in; AXI4-Lite on ref_clk_in
`timescale 1ns/10ps
`include "bmf_cfg.svh"

// Operation
// - Master reset edge loads default offsets 64/16/8
// - Select LL with mode high: parallel offset load
// - Mode low, any select: no offset load; offsets keep their values
// - Two offset registers: almost-empty, almost-full
// - Port A writes FIFO or A-to-B mailbox
// - Port A reads B-to-A mailbox, sets flag
// - Port B writes B-to-A mailbox, else floats
// - Port B drives FIFO output, strobe reads
// - Port B reads A-to-B mailbox, sets flag
// - Zero words: almost-empty low, empty low unless fall-through holds a word; others high
// - Almost-empty low up to offset; empty if none
// - Almost-full at depth minus offset; full at depth
// - Read flags on B side, write flags A side; here all flags are registered on ref_clk_in
// - Output register word is not counted
// - Fetched word frees its memory location
// - Flags mean ready in fall-through, else empty/full
// - Bus match off: whole word, same lanes
// - Word size: two halves, endian order
// - Byte size: four bytes, endian order
// - Endian latched at reset; sizes held static
// - Mailbox write clears flag; blocks further writes
// - Remainder of fetched word kept for later reads
module bmf_port_ctrl (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic full_reset_one_n_in,
   input wire logic serial_program_mode_in,
   input wire logic offset_sel1_serial_enable_in,
   input wire logic offset_sel0_serial_data_in,
   input wire logic big_endian_select_in,
   input wire logic fall_through_mode_in,
   input wire logic bus_match_select_in,
   input wire logic port_b_size_select_in,
   input wire logic port_a_clock_in,
   input wire logic port_a_select_n_in,
   input wire logic port_a_direction_in,
   input wire logic port_a_strobe_in,
   input wire logic port_a_mailbox_pick_in,
   input wire logic [35:0] port_a_data_in,
   output logic [35:0] port_a_data_out,
   output logic port_a_data_oe_out,
   input wire logic port_b_clock_in,
   input wire logic port_b_select_n_in,
   input wire logic port_b_direction_in,
   input wire logic port_b_strobe_in,
   input wire logic port_b_mailbox_pick_in,
   input wire logic [35:0] port_b_data_in,
   output logic [35:0] port_b_data_out,
   output logic port_b_data_oe_out,
   output logic empty_or_output_ready_out,
   output logic almost_empty_flag_out,
   output logic almost_full_flag_out,
   output logic full_or_input_ready_out,
   output logic a_to_b_mail_flag_out,
   output logic b_to_a_mail_flag_out,
   input wire logic [31:0] axi_awaddr_in,
   input wire logic axi_awvalid_in,
   output logic axi_awready_out,
   input wire logic [31:0] axi_wdata_in,
   input wire logic [3:0] axi_wstrb_in,
   input wire logic axi_wvalid_in,
   output logic axi_wready_out,
   output logic [1:0] axi_bresp_out,
   output logic axi_bvalid_out,
   input wire logic axi_bready_in,
   input wire logic [31:0] axi_araddr_in,
   input wire logic axi_arvalid_in,
   output logic axi_arready_out,
   output logic [31:0] axi_rdata_out,
   output logic [1:0] axi_rresp_out,
   output logic axi_rvalid_out,
   input wire logic axi_rready_in
);
   // ***********************************
   // State and helpers
   // ***********************************
   bmf_pkg::bmf_st_t st_q;
   bmf_pkg::bmf_st_t st_d;
   bmf_pkg::bmf_pins_t pins;
   bmf_pkg::bmf_pins_t p;
   logic [`BMF_DW-1:0] mem [0:`BMF_DEPTH-1];
   logic mem_we;
   logic inc;
   logic dec;
   logic fetch;
   logic pa_ev;
   logic pb_ev;
   logic fifo_wr;
   logic fifo_rd;
   logic last;
   logic mrs_rise;

   // Picks the piece of a long word shown on port B
   function automatic logic [35:0] bmf_piece(input logic [35:0] w, input logic [1:0] i,
                                             input logic bm, input logic sz, input logic be);
      logic [35:0] r;
      logic [1:0] k;
      r = '0;
      k = be ? ~i : i;
      if (!bm) begin
         r = w;
      end else if (!sz) begin
         r[17:0] = (be ? ~i[0] : i[0]) ? w[35:18] : w[17:0];
      end else begin
         r[8:0] = w[k*9 +: 9];
      end
      return r;
   endfunction : bmf_piece

   assign pins = '{pa_clk: port_a_clock_in, pa_sel_n: port_a_select_n_in,
                   pa_dir: port_a_direction_in, pa_stb: port_a_strobe_in,
                   pa_mb: port_a_mailbox_pick_in, pa_d: port_a_data_in,
                   pb_clk: port_b_clock_in, pb_sel_n: port_b_select_n_in,
                   pb_dir: port_b_direction_in, pb_stb: port_b_strobe_in,
                   pb_mb: port_b_mailbox_pick_in, pb_d: port_b_data_in,
                   mrs_n: full_reset_one_n_in, serial_program_mode: serial_program_mode_in,
                   fs1: offset_sel1_serial_enable_in, fs0: offset_sel0_serial_data_in,
                   be: big_endian_select_in, fall_through_mode: fall_through_mode_in,
                   bm: bus_match_select_in, size: port_b_size_select_in};

   // Only the second stage feeds logic
   assign p = st_q.s2;
   // Port clock edges found on synchronised copies
   assign pa_ev = p.pa_clk & ~st_q.a3 & ~p.pa_sel_n & p.pa_stb;
   assign pb_ev = p.pb_clk & ~st_q.b3 & ~p.pb_sel_n & p.pb_stb;
   assign mrs_rise = p.mrs_n & ~st_q.m3;
   assign fifo_wr = pa_ev & p.pa_dir & ~p.pa_mb & st_q.live;
   assign fifo_rd = pb_ev & p.pb_dir & ~p.pb_mb & st_q.live;
   assign last = ~p.bm | (p.size ? (st_q.lane == 2'h3) : (st_q.lane == 2'h1));

   // ***********************************
   // Next state
   // ***********************************
   always_comb begin
      st_d = st_q;
      mem_we = 1'b0;
      inc = 1'b0;
      dec = 1'b0;
      fetch = 1'b0;
      st_d.s1 = pins;
      st_d.s2 = st_q.s1;
      st_d.a3 = p.pa_clk;
      st_d.b3 = p.pb_clk;
      st_d.m3 = p.mrs_n;

      // Register bus: both write channels taken together
      st_d.awr = ~st_q.awr & ~st_q.bv & axi_awvalid_in & axi_wvalid_in;
      if (st_q.awr) begin
         st_d.bv = 1'b1;
         st_d.bresp = `BMF_RESP_SLVERR;
         if (axi_awaddr_in == `BMF_OFFS_ADDR) begin
            st_d.bresp = `BMF_RESP_OKAY;
            if (axi_wstrb_in[1:0] == 2'h3) begin
               st_d.x = axi_wdata_in[`BMF_X_LSB +: `BMF_PTR_W];
            end
            if (axi_wstrb_in[3:2] == 2'h3) begin
               st_d.y = axi_wdata_in[`BMF_Y_LSB +: `BMF_PTR_W];
            end
         end
      end else if (st_q.bv & axi_bready_in) begin
         st_d.bv = 1'b0;
      end
      st_d.arr = ~st_q.arr & ~st_q.rv & axi_arvalid_in;
      if (st_q.arr) begin
         st_d.rv = 1'b1;
         st_d.rresp = `BMF_RESP_OKAY;
         st_d.rdata = '0;
         if (axi_araddr_in == `BMF_OFFS_ADDR) begin
            st_d.rdata[`BMF_X_LSB +: `BMF_PTR_W] = st_q.x;
            st_d.rdata[`BMF_Y_LSB +: `BMF_PTR_W] = st_q.y;
         end else if (axi_araddr_in == `BMF_STAT_ADDR) begin
            st_d.rdata = {11'h000, st_q.be, st_q.lane, st_q.live, st_q.valid, 5'h00, st_q.cnt};
         end else begin
            st_d.rresp = `BMF_RESP_SLVERR;
         end
      end else if (st_q.rv & axi_rready_in) begin
         st_d.rv = 1'b0;
      end

      if (!p.mrs_n) begin
         // Master reset held: flush and rearm
         st_d.live = 1'b0;
         st_d.wp = '0;
         st_d.rp = '0;
         st_d.cnt = '0;
         st_d.valid = 1'b0;
         st_d.lane = 2'h0;
         st_d.prog = 2'h0;
         st_d.mf1 = 1'b1;
         st_d.mf2 = 1'b1;
      end else begin
         if (mrs_rise) begin
            st_d.live = 1'b1;
            st_d.be = p.be;
            case ({p.serial_program_mode, p.fs1, p.fs0})
               3'h7: begin
                  st_d.x = `BMF_OFS_64;
                  st_d.y = `BMF_OFS_64;
               end
               3'h6: begin
                  st_d.x = `BMF_OFS_16;
                  st_d.y = `BMF_OFS_16;
               end
               3'h5: begin
                  st_d.x = `BMF_OFS_8;
                  st_d.y = `BMF_OFS_8;
               end
               3'h4: st_d.prog = 2'h2;
               default: st_d.prog = 2'h0;
            endcase
         end
         if (pb_ev & p.pb_dir & p.pb_mb) begin
            st_d.mf1 = 1'b1;
         end
         if (pa_ev & p.pa_dir & p.pa_mb & st_q.mf1) begin
            st_d.mb1 = p.pa_d;
            st_d.mf1 = 1'b0;
         end
         if (pa_ev & ~p.pa_dir & p.pa_mb) begin
            st_d.mf2 = 1'b1;
         end
         if (pb_ev & ~p.pb_dir & p.pb_mb & st_q.mf2) begin
            st_d.mb2 = p.pb_d;
            st_d.mf2 = 1'b0;
         end
         // FIFO write, or parallel offset load
         if (fifo_wr) begin
            if (st_q.prog != 2'h0) begin
               if (st_q.prog == 2'h2) begin
                  st_d.x = p.pa_d[`BMF_PTR_W-1:0];
               end else begin
                  st_d.y = p.pa_d[`BMF_PTR_W-1:0];
               end
               st_d.prog = st_q.prog - 2'h1;
            end else if (st_q.cnt != `BMF_DEPTH) begin
               mem_we = 1'b1;
               st_d.wp = st_q.wp + 10'h001;
               inc = 1'b1;
            end
         end
         // Read: next piece or new fetch
         if (p.fall_through_mode) begin
            if (!st_q.valid) begin
               fetch = st_q.cnt != '0;
            end else if (fifo_rd) begin
               if (!last) begin
                  st_d.lane = st_q.lane + 2'h1;
               end else if (st_q.cnt != '0) begin
                  fetch = 1'b1;
               end else begin
                  st_d.valid = 1'b0;
               end
            end
         end else if (fifo_rd) begin
            if (st_q.valid & ~last) begin
               st_d.lane = st_q.lane + 2'h1;
            end else if (st_q.cnt != '0) begin
               fetch = 1'b1;
            end
         end
         // Fetch frees the slot, lowers count
         if (fetch) begin
            st_d.word = mem[st_q.rp];
            st_d.rp = st_q.rp + 10'h001;
            st_d.lane = 2'h0;
            st_d.valid = 1'b1;
            dec = 1'b1;
         end
         st_d.cnt = st_q.cnt + {10'h000, inc} - {10'h000, dec};
      end

      // Port drivers; enables come from pins already synchronised
      st_d.pa_oe = ~p.pa_sel_n & ~p.pa_dir;
      st_d.pa_do = st_d.mb2;
      st_d.pb_oe = ~p.pb_sel_n & p.pb_dir;
      st_d.pb_do = p.pb_mb ? st_d.mb1 : bmf_piece(st_d.word, st_d.lane, p.bm, p.size, st_d.be);
      st_d.ef = st_d.live & (p.fall_through_mode ? st_d.valid : (st_d.cnt != '0));
      st_d.ae = st_d.live & (st_d.cnt > {1'b0, st_d.x});
      st_d.af = ~st_d.live | (st_d.cnt < (`BMF_DEPTH - {1'b0, st_d.y}));
      st_d.ff = st_d.live & (st_d.cnt != `BMF_DEPTH);
   end

   // ***********************************
   // Registers
   // ***********************************
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_q <= '0;
         st_q.mf1 <= 1'b1;
         st_q.mf2 <= 1'b1;
         st_q.af <= 1'b1;
         // Idle select, so port A does not drive for two cycles after reset
         st_q.s1.pa_sel_n <= 1'b1;
         st_q.s2.pa_sel_n <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // Array kept out of reset so it maps to RAM
   always_ff @(posedge ref_clk_in) begin
      if (mem_we) begin
         mem[st_q.wp] <= p.pa_d;
      end
   end

   // All flags share the one clock
   assign port_a_data_out = st_q.pa_do;
   assign port_a_data_oe_out = st_q.pa_oe;
   assign port_b_data_out = st_q.pb_do;
   assign port_b_data_oe_out = st_q.pb_oe;
   assign empty_or_output_ready_out = st_q.ef;
   assign almost_empty_flag_out = st_q.ae;
   assign almost_full_flag_out = st_q.af;
   assign full_or_input_ready_out = st_q.ff;
   assign a_to_b_mail_flag_out = st_q.mf1;
   assign b_to_a_mail_flag_out = st_q.mf2;
   assign axi_awready_out = st_q.awr;
   assign axi_wready_out = st_q.awr;
   assign axi_bvalid_out = st_q.bv;
   assign axi_bresp_out = st_q.bresp;
   assign axi_arready_out = st_q.arr;
   assign axi_rvalid_out = st_q.rv;
   assign axi_rresp_out = st_q.rresp;
   assign axi_rdata_out = st_q.rdata;

   // ***********************************
   // Checks
   // ***********************************
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   default_ofs_a: assert property (mrs_rise & ({p.serial_program_mode, p.fs1, p.fs0} == 3'h7)
      |=> (st_q.x == `BMF_OFS_64) && (st_q.y == `BMF_OFS_64))
      else $error("default offset not loaded");
   mail_set_a: assert property (pa_ev & p.pa_dir & p.pa_mb & st_q.mf1 & p.mrs_n
      |=> !a_to_b_mail_flag_out ##1 !a_to_b_mail_flag_out || $past(pb_ev))
      else $error("mailbox flag not lowered");
   mail_block_a: assert property (pa_ev & p.pa_dir & p.pa_mb & !st_q.mf1
      |=> $stable(st_q.mb1))
      else $error("mailbox overwritten while full");
   mail_read_a: assert property (pb_ev & p.pb_dir & p.pb_mb & p.mrs_n
      & !(pa_ev & p.pa_dir & p.pa_mb) |=> a_to_b_mail_flag_out)
      else $error("mailbox flag not raised on read");
   full_ignore_a: assert property (fifo_wr & p.mrs_n & (st_q.prog == 2'h0)
      & (st_q.cnt == `BMF_DEPTH) |=> $stable(st_q.wp)
      && (st_q.cnt == `BMF_DEPTH - {10'h000, $past(fetch)}))
      else $error("write accepted while full");
   empty_flags_a: assert property (st_q.live & (st_q.cnt == '0)
      |-> !almost_empty_flag_out && almost_full_flag_out && full_or_input_ready_out)
      else $error("flags wrong at zero words");
   ae_level_a: assert property (st_q.live
      |-> almost_empty_flag_out == (st_q.cnt > {1'b0, st_q.x}))
      else $error("almost-empty flag off threshold");
   af_level_a: assert property (st_q.live |-> (almost_full_flag_out
      == (st_q.cnt < `BMF_DEPTH - {1'b0, st_q.y})) && (full_or_input_ready_out
      == (st_q.cnt != `BMF_DEPTH)))
      else $error("almost-full or full flag wrong");
   lane_step_a: assert property (fifo_rd & st_q.valid & !last & p.mrs_n
      |=> st_q.lane == $past(st_q.lane) + 2'h1)
      else $error("narrow read did not advance");
   oe_b_a: assert property (!p.pb_sel_n & p.pb_dir |=> port_b_data_oe_out)
      else $error("port B not driven");

   fill_c: cover property (st_q.live & (st_q.cnt == `BMF_DEPTH));
   byte_c: cover property (fifo_rd & p.bm & p.size & (st_q.lane == 2'h3));
   mail_c: cover property (!st_q.mf1 ##[1:20] st_q.mf1);
   fall_c: cover property (p.fall_through_mode & fetch & !st_q.valid);
endmodule : bmf_port_ctrl

//--- dv/bmf_host.sv
// Host model for both ports: each port is a master that strobes one operation at a time
// Assumes clk_in is the block reference clock; port clocks stand still between operations
`timescale 1ns/10ps
module bmf_host (
   input wire logic clk_in,
   output logic a_clk_out,
   output logic a_sel_n_out,
   output logic a_dir_out,
   output logic a_stb_out,
   output logic a_mb_out,
   output logic [35:0] a_d_out,
   output logic b_clk_out,
   output logic b_sel_n_out,
   output logic b_dir_out,
   output logic b_stb_out,
   output logic b_mb_out,
   output logic [35:0] b_d_out
);
   logic [40:0] a_q = 41'h080_0000_0000;
   logic [40:0] b_q = 41'h080_0000_0000;
   assign {a_clk_out, a_sel_n_out, a_dir_out, a_stb_out, a_mb_out, a_d_out} = a_q;
   assign {b_clk_out, b_sel_n_out, b_dir_out, b_stb_out, b_mb_out, b_d_out} = b_q;
   // ***********************************
   // Port cycle
   // ***********************************
   task automatic put(input logic pb, input logic [40:0] v);
      @(posedge clk_in);
      if (pb) begin
         b_q <= v;
      end else begin
         a_q <= v;
      end
      repeat (4) @(posedge clk_in);
   endtask : put
   // Five reference periods per clock phase, above the sampling minimum
   task automatic op(input logic pb, input logic [3:0] c, input logic [35:0] d);
      put(pb, {1'b0, c, d});
      put(pb, {1'b1, c, d});
      // Strobe dropped, data released to the inverse so no stale value lingers
      put(pb, {1'b0, c[3], c[2], 1'b0, c[0], ~d});
   endtask : op
endmodule : bmf_host

//--- dv/tb.sv
// Self-checking bench for the FIFO port control block
// Assumes bmf_host drives both ports; offsets and status read over AXI4-Lite
`timescale 1ns/10ps
`include "bmf_cfg.svh"
module tb;
   localparam int WD_CYC = 70000;
   logic ref_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic full_reset_one_n_in = 1'b0;
   logic [6:0] strap = 7'h00;
   logic [31:0] axi_awaddr_in = 32'h0000_0000;
   logic [31:0] axi_araddr_in = 32'h0000_0000;
   logic [31:0] axi_wdata_in = 32'h0000_0000;
   logic [3:0] axi_wstrb_in = 4'hF;
   logic axi_awvalid_in = 1'b0;
   logic axi_wvalid_in = 1'b0;
   logic axi_bready_in = 1'b0;
   logic axi_arvalid_in = 1'b0;
   logic axi_rready_in = 1'b0;
   logic axi_awready_out, axi_wready_out, axi_bvalid_out, axi_arready_out, axi_rvalid_out;
   logic [1:0] axi_bresp_out, axi_rresp_out;
   logic [31:0] axi_rdata_out;
   logic port_a_clock_in, port_a_select_n_in, port_a_direction_in, port_a_strobe_in;
   logic port_b_clock_in, port_b_select_n_in, port_b_direction_in, port_b_strobe_in;
   logic port_a_mailbox_pick_in, port_b_mailbox_pick_in, port_a_data_oe_out, port_b_data_oe_out;
   logic [35:0] port_a_data_in, port_b_data_in, port_a_data_out, port_b_data_out;
   logic empty_or_output_ready_out, almost_empty_flag_out, almost_full_flag_out;
   logic full_or_input_ready_out, a_to_b_mail_flag_out, b_to_a_mail_flag_out;
   wire logic [5:0] fl = {empty_or_output_ready_out, almost_empty_flag_out, almost_full_flag_out,
      full_or_input_ready_out, a_to_b_mail_flag_out, b_to_a_mail_flag_out};
   int n_fail = 0;
   int samples_checked = 0;
   always #12.5 ref_clk_in = ~ref_clk_in;
   bmf_port_ctrl DUT (.ref_clk_in, .rst_n_in, .full_reset_one_n_in,
      .serial_program_mode_in(strap[6]), .offset_sel1_serial_enable_in(strap[5]),
      .offset_sel0_serial_data_in(strap[4]), .big_endian_select_in(strap[3]),
      .fall_through_mode_in(strap[2]), .bus_match_select_in(strap[1]),
      .port_b_size_select_in(strap[0]), .port_a_clock_in, .port_a_select_n_in,
      .port_a_direction_in, .port_a_strobe_in, .port_a_mailbox_pick_in, .port_a_data_in,
      .port_a_data_out, .port_a_data_oe_out, .port_b_clock_in, .port_b_select_n_in,
      .port_b_direction_in, .port_b_strobe_in, .port_b_mailbox_pick_in, .port_b_data_in,
      .port_b_data_out, .port_b_data_oe_out, .empty_or_output_ready_out,
      .almost_empty_flag_out, .almost_full_flag_out, .full_or_input_ready_out,
      .a_to_b_mail_flag_out, .b_to_a_mail_flag_out, .axi_awaddr_in, .axi_awvalid_in,
      .axi_awready_out, .axi_wdata_in, .axi_wstrb_in, .axi_wvalid_in, .axi_wready_out,
      .axi_bresp_out, .axi_bvalid_out, .axi_bready_in, .axi_araddr_in, .axi_arvalid_in,
      .axi_arready_out, .axi_rdata_out, .axi_rresp_out, .axi_rvalid_out, .axi_rready_in);
   bmf_host host (.clk_in(ref_clk_in), .a_clk_out(port_a_clock_in),
      .a_sel_n_out(port_a_select_n_in), .a_dir_out(port_a_direction_in),
      .a_stb_out(port_a_strobe_in), .a_mb_out(port_a_mailbox_pick_in), .a_d_out(port_a_data_in),
      .b_clk_out(port_b_clock_in), .b_sel_n_out(port_b_select_n_in),
      .b_dir_out(port_b_direction_in), .b_stb_out(port_b_strobe_in),
      .b_mb_out(port_b_mailbox_pick_in), .b_d_out(port_b_data_in));
   // ***********************************
   // Shared tasks
   // ***********************************
   task automatic chk(input string n, input logic [35:0] e, input logic [35:0] s);
      samples_checked++;
      if (s !== e) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   function automatic logic [35:0] wd(input int i);
      return {10'(i), ~10'(i), 10'(i), 6'h2A};
   endfunction : wd
   // Flags for a stored count with X=2, Y=3, both mail flags idle
   function automatic logic [35:0] exp_f(input int c);
      return {30'h0, c != 0, c > 2, c < 1021, c < 1024, 2'b11};
   endfunction : exp_f
   task automatic axw(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge ref_clk_in);
      axi_awaddr_in <= a;
      axi_wdata_in <= d;
      {axi_awvalid_in, axi_wvalid_in, axi_bready_in} <= 3'h7;
      do begin
         @(posedge ref_clk_in);
         if (axi_awready_out === 1'b1) axi_awvalid_in <= 1'b0;
         if (axi_wready_out === 1'b1) axi_wvalid_in <= 1'b0;
      end while (axi_bvalid_out !== 1'b1);
      r = axi_bresp_out;
      axi_bready_in <= 1'b0;
   endtask : axw
   task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge ref_clk_in);
      axi_araddr_in <= a;
      {axi_arvalid_in, axi_rready_in} <= 2'h3;
      do begin
         @(posedge ref_clk_in);
         if (axi_arready_out === 1'b1) axi_arvalid_in <= 1'b0;
      end while (axi_rvalid_out !== 1'b1);
      d = axi_rdata_out;
      r = axi_rresp_out;
      axi_rready_in <= 1'b0;
   endtask : axr
   // Straps settle before the release edge; only t_narrow changes one (strap[3]) afterwards
   task automatic mr(input logic [6:0] s);
      @(posedge ref_clk_in);
      full_reset_one_n_in <= 1'b0;
      strap <= s;
      repeat (4) @(posedge ref_clk_in);
      full_reset_one_n_in <= 1'b1;
      repeat (6) @(posedge ref_clk_in);
   endtask : mr
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : wrap_up
   // ***********************************
   // Scenarios
   // ***********************************
   task automatic t_defaults();
      logic [31:0] v;
      logic [1:0] r;
      logic [9:0] ofs [3] = '{10'h040, 10'h010, 10'h008};
      for (int i = 0; i < 3; i++) begin
         mr({1'b1, 2'(3 - i), 4'h0});
         axr(`BMF_OFFS_ADDR, v, r);
         chk("default offsets", {10'h000, ofs[i], 6'h00, ofs[i]}, {4'h0, v});
         chk("reset flags", 36'h0_0000_000F, {30'h0, fl});
      end
   endtask : t_defaults
   task automatic t_regs();
      logic [31:0] v;
      logic [1:0] r;
      mr(7'h20);
      axw(`BMF_OFFS_ADDR, 32'h0003_0002, r);
      chk("offs resp", {34'h0, `BMF_RESP_OKAY}, {34'h0, r});
      axr(`BMF_OFFS_ADDR, v, r);
      chk("offs back", 36'h0_0003_0002, {4'h0, v});
      axr(32'h0000_0040, v, r);
      chk("unmapped resp", {34'h0, `BMF_RESP_SLVERR}, {34'h0, r});
      axw(`BMF_STAT_ADDR, 32'hFFFF_FFFF, r);
      chk("status write", {34'h0, `BMF_RESP_SLVERR}, {34'h0, r});
   endtask : t_regs
   task automatic t_fill();
      logic [31:0] v;
      logic [1:0] r;
      for (int n = 1; n <= 1025; n++) begin
         host.op(1'b0, 4'b0110, wd(n - 1));
         chk("fill flags", exp_f(n > 1024 ? 1024 : n), {30'h0, fl});
      end
      axr(`BMF_STAT_ADDR, v, r);
      chk("full count", 36'h0_0000_0400, {25'h0, v[10:0]});
      for (int k = 1; k <= 1025; k++) begin
         host.op(1'b1, 4'b0110, 36'h0_0000_0000);
         chk("fifo data", wd(k > 1024 ? 1023 : k - 1), port_b_data_out);
         chk("drain flags", exp_f(k > 1024 ? 0 : 1024 - k), {30'h0, fl});
      end
   endtask : t_fill
   task automatic t_parallel();
      logic [31:0] v;
      logic [1:0] r;
      mr(7'h40);
      host.op(1'b0, 4'b0110, 36'h0_0000_0005);
      host.op(1'b0, 4'b0110, 36'h0_0000_0007);
      axr(`BMF_OFFS_ADDR, v, r);
      chk("parallel offs", 36'h0_0007_0005, {4'h0, v});
      chk("parallel flags", exp_f(0), {30'h0, fl});
   endtask : t_parallel
   task automatic t_fall_through_mode();
      logic [31:0] v;
      logic [1:0] r;
      mr(7'h74);
      host.op(1'b0, 4'b0110, wd(5));
      chk("fall data", wd(5), port_b_data_out);
      chk("fall flags", 36'h0_0000_002F, {30'h0, fl});
      axr(`BMF_STAT_ADDR, v, r);
      chk("fall count", 36'h0_0000_0800, {24'h0, v[16], v[10:0]});
      host.op(1'b1, 4'b0110, 36'h0_0000_0000);
      chk("fall drained", 36'h0_0000_000F, {30'h0, fl});
   endtask : t_fall_through_mode
   task automatic t_narrow();
      logic [35:0] w0;
      logic [35:0] e;
      int n;
      int sh;
      w0 = 36'h8_D159_E26B;
      for (int m = 0; m < 4; m++) begin
         mr({3'b111, m[0], 1'b0, 1'b1, m[1]});
         strap[3] <= ~m[0];
         n = m[1] ? 4 : 2;
         sh = 36 / n;
         host.op(1'b0, 4'b0110, w0);
         host.op(1'b0, 4'b0110, ~w0);
         for (int k = 0; k < 2 * n; k++) begin
            host.op(1'b1, 4'b0110, 36'h0_0000_0000);
            e = k < n ? w0 : ~w0;
            e = e >> (sh * (m[0] ? n - 1 - k % n : k % n));
            e = e & ((36'h0_0000_0001 << sh) - 1);
            chk("narrow piece", e, port_b_data_out);
         end
      end
   endtask : t_narrow
   task automatic t_mail();
      mr(7'h70);
      host.op(1'b0, 4'b0111, 36'hA_5A5A_1234);
      host.op(1'b0, 4'b0111, 36'h0_0000_0000);
      chk("a_to_b_mailbox flag", 36'h0_0000_000D, {30'h0, fl});
      host.op(1'b1, 4'b0111, 36'h0_0000_0000);
      chk("a_to_b_mailbox data", 36'hA_5A5A_1234, port_b_data_out);
      chk("a_to_b_mailbox read", 36'h0_0000_004F, {29'h0, port_b_data_oe_out, fl});
      host.op(1'b1, 4'b0011, 36'h5_0F0F_7788);
      chk("b_to_a_mailbox write", 36'h0_0000_000E, {29'h0, port_b_data_oe_out, fl});
      host.op(1'b0, 4'b0011, 36'h0_0000_0000);
      chk("b_to_a_mailbox data", 36'h5_0F0F_7788, port_a_data_out);
      chk("b_to_a_mailbox read", 36'h0_0000_004F, {29'h0, port_a_data_oe_out, fl});
      host.op(1'b0, 4'b1111, 36'h0_0000_0001);
      host.op(1'b1, 4'b0010, 36'h0_0000_0002);
      chk("idle ports", 36'h0_0000_000F,
         {28'h0, port_a_data_oe_out, port_b_data_oe_out, fl});
   endtask : t_mail
   // ***********************************
   // Run
   // ***********************************
   initial begin
      repeat (16) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      t_defaults();
      t_regs();
      t_fill();
      t_parallel();
      t_fall_through_mode();
      t_narrow();
      t_mail();
      wrap_up();
   end
   initial begin
      repeat (WD_CYC) @(posedge ref_clk_in);
      n_fail++;
      wrap_up();
   end
endmodule : tb
